// ### interval_watchdog_timer.sv
// interval timer / watchdog with ahb-lite register slave
// assumes one master, single word transfers, hclk is fx
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module interval_watchdog_timer import wdt_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic stop_request,
  input wire logic wake_event,
  output logic cpu_halt,
  output logic wdt_reset,
  output logic irq
);
  logic tick;
  logic [3:0] mode_q;
  logic [3:0] mode_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic irq_flag_q;
  logic irq_flag_d;
  logic wdog_q;
  logic wdog_d;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic wreq_q;
  logic wreq_d;
  logic [13:0] waddr_q;
  logic [13:0] waddr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rst_q;
  logic rst_d;
  standby_t sb_q;
  standby_t sb_d;
  logic stop_m_q;
  logic stop_s_q;
  logic wake_m_q;
  logic wake_s_q;
  logic ovf;
  logic start;
  logic setup;
  logic do_wr;
  logic [3:0] wval;

  // one decoder for the wdog, status and mask write strobes
  function automatic logic wr_hit(input logic wr, input logic [13:0] wa, input logic [13:0] a);
    return wr && (wa == a);
  endfunction

  // prescaler is not restarted by a start, so the first tick may come early
  wdt_prescaler #(.WIDTH(12)) u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(mode_q[2:0]),
    .tick(tick)
  );

  // pins come from outside hclk logic, two flops before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_m_q <= 1'b0;
      stop_s_q <= 1'b0;
    end else begin
      stop_m_q <= stop_request;
      stop_s_q <= stop_m_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_m_q <= 1'b0;
      wake_s_q <= 1'b0;
    end else begin
      wake_m_q <= wake_event;
      wake_s_q <= wake_m_q;
    end
  end

  assign setup = hsel && hready && htrans[1];
  assign do_wr = wreq_q;
  assign wval = hwdata[3:0];
  assign start = do_wr && ((waddr_q == MODE_ADDR && wval[START_BIT]) ||
    (waddr_q == START_ADDR && hwdata[0]));
  assign ovf = tick && (count_q == 8'hff);

  // zero wait states: the address phase is taken on the edge it is seen
  always_comb begin
    wreq_d = setup && hwrite;
    waddr_d = setup ? haddr[13:0] : waddr_q;
  end

  // read data stands for the data phase only, zero otherwise
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (setup && !hwrite) begin
      unique case (haddr[13:0])
        MODE_ADDR: rdata_d = {28'h0, mode_q};
        COUNT_ADDR: rdata_d = {24'h0, count_q};
        WDOG_ADDR: rdata_d = {31'h0, wdog_q};
        START_ADDR: rdata_d = 32'h0000_0000;
        STATUS_ADDR: rdata_d = {30'h0, status_q};
        MASK_ADDR: rdata_d = {30'h0, mask_q};
        STANDBY_ADDR: rdata_d = {30'h0, sb_q != RUN, irq_flag_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    mode_d = mode_q;
    if (do_wr && waddr_q == MODE_ADDR) begin
      mode_d = {1'b0, wval[2:0]}; // low three bits only; start bit self-clears
    end
  end

  // counter writes are not decoded, so stores to it are lost
  // the count may move between two reads; software reads it twice
  always_comb begin
    count_d = count_q;
    if (start) begin
      count_d = COUNT_RESET;
    end else if (tick) begin
      count_d = count_q + 8'h01; // wraps to zero after overflow
    end
  end

  // standby sequencer: overflow ends the settling wait
  always_comb begin
    sb_d = sb_q;
    unique case (sb_q)
      RUN: begin
        if (stop_s_q) begin
          sb_d = STOP_SLEEP;
        end
      end
      STOP_SLEEP: begin
        if (wake_s_q) begin
          sb_d = STOP_WAIT;
        end
      end
      STOP_WAIT: begin
        if (ovf) begin
          sb_d = RUN;
        end
      end
    endcase
  end
  assign cpu_halt = sb_q != RUN;

  always_comb begin
    irq_flag_d = irq_flag_q;
    if (start) begin
      irq_flag_d = 1'b0;
    end
    // later assignment, so a same-cycle overflow still sets the flag
    if (ovf && !wdog_q) begin
      irq_flag_d = 1'b1;
    end
  end

  // watchdog flag only ever set from software; no clear path exists
  always_comb begin
    wdog_d = wdog_q;
    if (wr_hit(do_wr, waddr_q, WDOG_ADDR) && hwdata[0]) begin
      wdog_d = 1'b1;
    end
  end

  // stop-release wait overflow never resets
  // one-cycle pulse; the system reset logic outside stretches it
  always_comb begin
    rst_d = 1'b0;
    if (ovf && wdog_q && sb_q != STOP_WAIT) begin
      rst_d = 1'b1;
    end
  end

  // write-one-to-clear first, then sets, so an event beats a clear
  always_comb begin
    status_d = status_q;
    if (wr_hit(do_wr, waddr_q, STATUS_ADDR)) begin
      status_d = status_q & ~hwdata[1:0];
    end
    if (ovf && !wdog_q) begin
      status_d[ST_OVF] = 1'b1;
    end
    if (sb_q == STOP_WAIT && ovf) begin
      status_d[ST_WAKE] = 1'b1;
    end
  end

  always_comb begin
    mask_d = mask_q;
    if (wr_hit(do_wr, waddr_q, MASK_ADDR)) begin
      mask_d = hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_flag_q <= 1'b0;
    end else begin
      irq_flag_q <= irq_flag_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_q <= 1'b0;
    end else begin
      wdog_q <= wdog_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 2'b00;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= 2'b00;
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wreq_q <= 1'b0;
      waddr_q <= 14'h0000;
    end else begin
      wreq_q <= wreq_d;
      waddr_q <= waddr_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= rst_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sb_q <= RUN;
    end else begin
      sb_q <= sb_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdt_reset = rst_q;
  assign irq = |(status_q & mask_q);
endmodule // interval_watchdog_timer
`default_nettype wire

// ### wdt_pkg.sv
// constants and types shared by the interval timer / watchdog block
// assumes a single clock domain (hclk) and an ahb-lite register slave
package wdt_pkg;

  // word byte addresses; mode register printed at 0xf85 (not a multiple of four)
  localparam logic [11:0] MODE_IDX = 12'hf85;
  localparam logic [13:0] MODE_ADDR = {MODE_IDX, 2'b00};
  localparam logic [13:0] COUNT_ADDR = 14'h3e18;
  localparam logic [13:0] WDOG_ADDR = 14'h3e1c;
  localparam logic [13:0] START_ADDR = 14'h3e20;
  localparam logic [13:0] STATUS_ADDR = 14'h3e24;
  localparam logic [13:0] MASK_ADDR = 14'h3e28;
  localparam logic [13:0] STANDBY_ADDR = 14'h3e2c;

  localparam int START_BIT = 3;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [11:0] PRESCALE_RESET = 12'h000;

  // status bits
  localparam int ST_OVF = 0;
  localparam int ST_WAKE = 1;

  // divider codes
  localparam logic [2:0] SEL_DIV12 = 3'b000;
  localparam logic [2:0] SEL_DIV9 = 3'b011;
  localparam logic [2:0] SEL_DIV7 = 3'b101;
  localparam logic [2:0] SEL_DIV5 = 3'b111;

  typedef enum logic [1:0] {
    AHB_IDLE = 2'b00,
    AHB_BUSY = 2'b01,
    AHB_NONSEQ = 2'b10,
    AHB_SEQ = 2'b11
  } htrans_t;

  typedef enum {RUN, STOP_SLEEP, STOP_WAIT} standby_t;

endpackage

// ### wdt_prescaler.sv
// free-running prescaler producing a one-cycle tick at the selected rate
// assumes hclk is the main system clock fx
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler import wdt_pkg::*; #(
  parameter int WIDTH = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] sel,
  output logic tick
);
  // the slowest tap reads bit 11, so a narrower counter cannot serve
  if (WIDTH < 12) begin : g_width_check
    $error("prescaler needs at least 12 bits");
  end

  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] nxt;

  always_comb begin
    nxt = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    cnt_d = nxt;
    // rising carry into the tap bit gives one tick per 2^n clocks
    unique case (sel)
      SEL_DIV9: tick = nxt[8:0] == 9'h000;
      SEL_DIV7: tick = nxt[6:0] == 7'h00;
      SEL_DIV5: tick = nxt[4:0] == 5'h00;
      default: tick = nxt[11:0] == 12'h000; // prohibited codes fall to slowest
    endcase
  end

  // never stopped, so the count keeps running through starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // wdt_prescaler
`default_nettype wire

// ### interval_watchdog_timer_properties.sv
// checker: port-level properties of the interval timer / watchdog
// assumes hready is fed back from hreadyout, one master
`timescale 1ns/1ps
`default_nettype none
module interval_watchdog_timer_properties import wdt_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cpu_halt,
  input wire logic wdt_reset,
  input wire logic irq
);
  logic ph_q;
  logic wr_q;
  logic [13:0] a_q;
  // track data phases; hrdata only stands there
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 14'h0;
    end else begin
      ph_q <= hsel && hready && htrans[1] && !hwrite;
      wr_q <= hsel && hready && htrans[1] && hwrite;
      a_q <= haddr[13:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_mode;
    ph_q && a_q == MODE_ADDR;
  endsequence
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_resp; !hresp; endproperty
  a_resp: assert property (p_resp) else $error("error response");
  property p_idle; !ph_q |-> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside data phase");
  property p_high; ph_q |-> hrdata[31:8] == 24'h0; endproperty
  a_high: assert property (p_high) else $error("upper read bits set");
  property p_start; s_rd_mode |-> !hrdata[START_BIT]; endproperty
  a_start: assert property (p_start) else $error("start bit reads one");
  property p_mode; s_rd_mode |-> hrdata[31:4] == 28'h0; endproperty
  a_mode: assert property (p_mode) else $error("mode wider than a nibble");
  property p_pulse; wdt_reset |=> !wdt_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  // interrupt only falls after a write or an internal reset
  property p_irq; irq && !wr_q && !wdt_reset && !$past(wdt_reset) |=> irq; endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped by itself");
endmodule // interval_watchdog_timer_properties
`default_nettype wire

// ### interval_watchdog_timer_bench.sv
// bench: drives the ahb-lite slave and the standby inputs directly
// assumes zero wait states are tolerated but never relied upon
`timescale 1ns/1ps
`default_nettype none
module interval_watchdog_timer_bench import wdt_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, stop_request, wake_event;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, cpu_halt, wdt_reset, irq;
  wire logic hready = hreadyout;
  int mismatches, n_tests, n;
  interval_watchdog_timer i_interval_watchdog_timer (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .stop_request(stop_request), .wake_event(wake_event),
    .cpu_halt(cpu_halt), .wdt_reset(wdt_reset), .irq(irq));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {18'h0, a};
    hwrite <= w;
    htrans <= AHB_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= AHB_IDLE;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      $display("MISMATCH %s expected %h seen %h", s, e, v);
      mismatches++;
    end
  endtask
  // bounded wait; n counts clocks so interval lengths can be judged
  task automatic wait_for(input int k);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (n < 9000 && (k == 0 ? irq !== 1'b1 : k == 1 ? cpu_halt !== 1'b1 :
      k == 2 ? cpu_halt !== 1'b0 : wdt_reset !== 1'b1));
  endtask
  task automatic final_report;
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #4000000;
    mismatches++;
    final_report();
  end
  initial begin
    {hresetn, hsel, hwrite, stop_request, wake_event, htrans} = 7'h0;
    {haddr, hwdata} = 64'h0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, MODE_ADDR, 32'h0); chk("mode", 32'h0, q);
    xfer(1'b1, MODE_ADDR, 32'hf);
    xfer(1'b0, COUNT_ADDR, 32'h0); chk("count", 32'h1, {31'h0, q < 32'h2});
    xfer(1'b0, MODE_ADDR, 32'h0); chk("mode", 32'h7, q);
    xfer(1'b1, COUNT_ADDR, 32'hff);
    xfer(1'b0, COUNT_ADDR, 32'h0); chk("count", 32'h1, {31'h0, q < 32'h4});
    xfer(1'b0, 14'h0, 32'h0); chk("unmapped", 32'h0, q);
    xfer(1'b1, MASK_ADDR, 32'h3);
    xfer(1'b1, START_ADDR, 32'h1);
    wait_for(0); chk("interval", 32'h1, {31'h0, n > 8100 && n < 8300});
    xfer(1'b0, STATUS_ADDR, 32'h0); chk("status", 32'h1, q);
    xfer(1'b0, STANDBY_ADDR, 32'h0); chk("flag", 32'h1, q);
    xfer(1'b1, MODE_ADDR, 32'hf);
    xfer(1'b0, STANDBY_ADDR, 32'h0); chk("flag", 32'h0, q);
    xfer(1'b1, STATUS_ADDR, 32'h1);
    @(negedge hclk); chk("irq", 32'h0, {31'h0, irq});
    @(posedge hclk);
    stop_request <= 1'b1;
    wait_for(1); chk("halt", 32'h1, {31'h0, cpu_halt});
    stop_request <= 1'b0;
    wake_event <= 1'b1;
    wait_for(2); chk("settle", 32'h1, {31'h0, n < 8300});
    wake_event <= 1'b0;
    xfer(1'b0, STATUS_ADDR, 32'h0); chk("wake", 32'h1, {31'h0, q[ST_WAKE]});
    xfer(1'b1, MODE_ADDR, {28'h0, 1'b1, SEL_DIV7});
    repeat (1300) @(posedge hclk);
    xfer(1'b0, COUNT_ADDR, 32'h0); chk("div7", 32'h1, {31'h0, q >= 32'ha && q <= 32'hb});
    xfer(1'b1, MODE_ADDR, {28'h0, 1'b1, SEL_DIV9});
    repeat (2600) @(posedge hclk);
    xfer(1'b0, COUNT_ADDR, 32'h0); chk("div9", 32'h1, {31'h0, q >= 32'h5 && q <= 32'h6});
    xfer(1'b1, MODE_ADDR, {28'h0, 1'b1, SEL_DIV12});
    repeat (8200) @(posedge hclk);
    xfer(1'b0, COUNT_ADDR, 32'h0); chk("div12", 32'h1, {31'h0, q >= 32'h2 && q <= 32'h3});
    xfer(1'b1, WDOG_ADDR, 32'h1);
    xfer(1'b1, WDOG_ADDR, 32'h0);
    xfer(1'b0, WDOG_ADDR, 32'h0); chk("wdog", 32'h1, q);
    xfer(1'b1, MODE_ADDR, 32'hf);
    wait_for(3); chk("bite", 32'h1, {31'h0, n > 8100 && n < 8300});
    final_report();
  end
endmodule // interval_watchdog_timer_bench
bind interval_watchdog_timer interval_watchdog_timer_properties i_props (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .cpu_halt(cpu_halt), .wdt_reset(wdt_reset), .irq(irq));
`default_nettype wire
